/* File: fsw_consts.svh */
// Purpose: constants of the flash status and write-protect block
// Assumes: included by bare name
// Notes:   bit positions, reset values and timing counts
`ifndef FSW_CONSTS_SVH
`define FSW_CONSTS_SVH

// status bit positions
`define FSW_BUSY_BIT            0
`define FSW_WEL_BIT             1
`define FSW_BP_LSB              2
`define FSW_BP_MSB              5
`define FSW_QE_BIT              6
`define FSW_REG_WRITE_DISABLE_BIT            7
`define FSW_STATUS_RESET        8'h00

// function register bit that places the protected region
`define FSW_FUNC_TBS_BIT        1

// density in 64 KB blocks
`define FSW_DEFAULT_BLOCKS      256

// timing
`define FSW_MCLK_PERIOD_NS      4
`define FSW_STATUS_WRITE_NS     400
`define FSW_STATUS_WRITE_CYCLES ((`FSW_STATUS_WRITE_NS + `FSW_MCLK_PERIOD_NS - 1) / `FSW_MCLK_PERIOD_NS)

`endif

/* File: fsw_pkg.sv */
// Purpose: types of the flash status and write-protect block
// Assumes: nothing
// Notes:   commands, array requests and states
package fsw_pkg;

  typedef enum logic [2:0] {
    fsw_op_none                  = 3'h0,
    fsw_op_set_write_latch_cmd   = 3'h1,
    fsw_op_clear_write_latch_cmd = 3'h2,
    fsw_op_write_status_cmd      = 3'h3,
    fsw_op_page_program          = 3'h4,
    fsw_op_sector_erase          = 3'h5,
    fsw_op_block_erase           = 3'h6,
    fsw_op_full_array_erase_cmd  = 3'h7
  } fsw_op_type;

  typedef struct packed {
    fsw_op_type op;
    logic [7:0] data;
    logic [7:0] block;
  } fsw_cmd_type;

  typedef struct packed {
    logic       start;
    fsw_op_type op;
    logic [7:0] block;
  } fsw_array_op_type;

  typedef enum logic [1:0] {
    fsw_st_idle         = 2'b00,
    fsw_st_status_write = 2'b01,
    fsw_st_array        = 2'b10
  } fsw_state_type;

endpackage

/* File: fsw_status_protect.sv */
// Purpose: status register, write-enable latch and block protection
// Assumes: commands arrive decoded on the link clock
// Notes:   non-volatile bits are modelled as reset-to-zero flops
//
// Overview of operation
// - status bit 0 reads 1 while a write, program or erase runs
// - with latch bit 1 clear, all writes, programs and erases are rejected
// - set-latch command sets the write-enable latch
// - clear-latch command clears the write-enable latch
// - latch clears itself when any write, program or erase completes
// - bits 2 to 5 select a protected region; operations there are refused
// - full erase ignored when any protect bit is set
// - disable bit set, bit 6 clear and protect pin low: status writes ignored
// - disable bit clear or protect pin high: status writes accepted
// - bit 6 turns protect/hold pins into data lines two and three
// - only status write changes stored bits; status read returns all
// - all eight status bits default to zero
// - placement select zero protects top blocks, one protects bottom
// - 256 blocks: level n protects 2^(n-1), levels 9 up protect all
// - 128 blocks: levels 1 to 7 as powers, top bit protects all
// - 64 blocks: levels 1 to 6 as powers, 7 up protects all
// - placement select is bit 1 of the one-time function register
`include "fsw_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module fsw_status_protect #(
  parameter int BLOCKS              = `FSW_DEFAULT_BLOCKS,
  parameter int STATUS_WRITE_CYCLES = `FSW_STATUS_WRITE_CYCLES
) (
  input  wire logic                      mclk_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      link_clk_in,
  input  wire logic                      link_cmd_valid_in,
  input  wire fsw_pkg::fsw_cmd_type      link_cmd_in,
  output var  logic                      link_cmd_ready_out,
  output var  logic [7:0]                link_status_out,
  input  wire logic [1:0]                link_quad_tx_in,
  input  wire logic [1:0]                link_quad_oe_in,
  output var  logic [1:0]                link_quad_rx_out,
  input  wire logic                      quad_data_line_two_in,
  output var  logic                      quad_data_line_two_out,
  output var  logic                      quad_data_line_two_oe_out,
  input  wire logic                      quad_data_line_three_in,
  output var  logic                      quad_data_line_three_out,
  output var  logic                      quad_data_line_three_oe_out,
  input  wire logic [7:0]                function_reg_in,
  input  wire logic                      array_done_in,
  output var  fsw_pkg::fsw_array_op_type array_op_out,
  output var  logic [7:0]                status_out,
  output var  logic                      hold_active_out
);
  import fsw_pkg::*;

  localparam int BW = $clog2(BLOCKS);

  if (!(BLOCKS == 64 || BLOCKS == 128 || BLOCKS == 256)) begin : g_bad_density
    $error("unsupported density");
  end
  if (STATUS_WRITE_CYCLES < 1 || STATUS_WRITE_CYCLES > 65535) begin : g_bad_cycles
    $error("status write count out of range");
  end

  ////////////////////////////////////////////////////////////
  // link domain: command capture and status mirror
  ////////////////////////////////////////////////////////////
  logic        req_tgl;
  fsw_cmd_type cmd_hold;
  logic        ack_tgl;
  logic        ack_s1;
  logic        ack_s2;
  logic        pub_tgl;
  logic [7:0]  pub_status;
  logic        pub_s1;
  logic        pub_s2;
  logic        pub_ack;
  wire         accept;
  wire         mirror_qe;

  assign accept    = link_cmd_valid_in & link_cmd_ready_out;
  assign mirror_qe = link_status_out[`FSW_QE_BIT];

  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      pub_s1 <= 1'b0;
      pub_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      pub_s1 <= pub_tgl;
      pub_s2 <= pub_s1;
    end
  end

  // one command in flight, held stable until acknowledged
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_tgl            <= 1'b0;
      cmd_hold           <= '0;
      link_cmd_ready_out <= 1'b0;
    end else begin
      if (accept) begin
        req_tgl  <= ~req_tgl;
        cmd_hold <= link_cmd_in;
      end
      link_cmd_ready_out <= ~accept & (ack_s2 == req_tgl);
    end
  end

  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pub_ack         <= 1'b0;
      link_status_out <= `FSW_STATUS_RESET;
    end else if (pub_s2 != pub_ack) begin
      pub_ack         <= pub_s2;
      link_status_out <= pub_status;
    end
  end

  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quad_data_line_two_out      <= 1'b0;
      quad_data_line_two_oe_out   <= 1'b0;
      quad_data_line_three_out    <= 1'b0;
      quad_data_line_three_oe_out <= 1'b0;
      link_quad_rx_out            <= 2'h0;
    end else begin
      quad_data_line_two_out      <= link_quad_tx_in[0];
      quad_data_line_two_oe_out   <= mirror_qe & link_quad_oe_in[0];
      quad_data_line_three_out    <= link_quad_tx_in[1];
      quad_data_line_three_oe_out <= mirror_qe & link_quad_oe_in[1];
      link_quad_rx_out            <= mirror_qe ? {quad_data_line_three_in, quad_data_line_two_in} : 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////
  // core domain: synchronisers
  ////////////////////////////////////////////////////////////
  logic req_s1;
  logic req_s2;
  logic pack_s1;
  logic pack_s2;
  logic wp_s1;
  logic wp_s2;
  logic hold_s1;
  logic hold_s2;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_s1  <= 1'b0;
      req_s2  <= 1'b0;
      pack_s1 <= 1'b0;
      pack_s2 <= 1'b0;
      wp_s1   <= 1'b1;
      wp_s2   <= 1'b1;
      hold_s1 <= 1'b1;
      hold_s2 <= 1'b1;
    end else begin
      req_s1  <= req_tgl;
      req_s2  <= req_s1;
      pack_s1 <= pub_ack;
      pack_s2 <= pack_s1;
      wp_s1   <= quad_data_line_two_in;
      wp_s2   <= wp_s1;
      hold_s1 <= quad_data_line_three_in;
      hold_s2 <= hold_s1;
    end
  end

  ////////////////////////////////////////////////////////////
  // core domain: status bits and decode
  ////////////////////////////////////////////////////////////
  fsw_state_type state;
  fsw_state_type next_state;
  logic [15:0]   cnt;
  logic          write_enable_latch;
  logic [3:0]    bp;
  logic          qe;
  logic          reg_write_disable;
  logic [7:0]    staged;
  wire           cmd_new;
  wire           idle;
  wire           busy;
  wire  [7:0]    status_now;
  wire           wp_level;
  wire           sr_locked;
  wire           protect_placement_select;
  wire  [3:0]    prot_shift;
  wire  [8:0]    prot_count;
  wire  [8:0]    blk_idx;
  wire           prot_hit;
  wire           is_area_op;
  wire           go_set;
  wire           go_clr;
  wire           go_write_status_cmd;
  wire           go_array;
  wire           sw_done;
  wire           arr_done;

  assign cmd_new = req_s2 != ack_tgl;
  assign idle    = state == fsw_st_idle;
  assign busy    = ~idle;
  assign status_now = {reg_write_disable, qe, bp, write_enable_latch, busy};

  // protect pin only while quad lines are off
  assign wp_level  = qe ? 1'b1 : wp_s2;
  assign sr_locked = reg_write_disable & ~wp_level;

  assign protect_placement_select        = function_reg_in[`FSW_FUNC_TBS_BIT];
  assign prot_shift = bp - 4'h1;
  assign prot_count = (bp == 4'h0) ? 9'h000 :
                      (prot_shift >= 4'(BW)) ? 9'(BLOCKS) :
                      (9'h001 << prot_shift);
  assign blk_idx    = 9'(cmd_hold.block[BW-1:0]);
  assign prot_hit   = protect_placement_select ? (blk_idx < prot_count) :
                            (blk_idx >= (9'(BLOCKS) - prot_count));

  assign is_area_op = cmd_hold.op == fsw_op_page_program ||
                      cmd_hold.op == fsw_op_sector_erase ||
                      cmd_hold.op == fsw_op_block_erase;

  assign go_set   = cmd_new & idle & (cmd_hold.op == fsw_op_set_write_latch_cmd);
  assign go_clr   = cmd_new & idle & (cmd_hold.op == fsw_op_clear_write_latch_cmd);
  assign go_write_status_cmd  = cmd_new & idle & write_enable_latch & ~sr_locked &
                    (cmd_hold.op == fsw_op_write_status_cmd);
  assign go_array = cmd_new & idle & write_enable_latch &
                    ((is_area_op & ~prot_hit) |
                     ((cmd_hold.op == fsw_op_full_array_erase_cmd) & (bp == 4'h0)));

  assign sw_done  = (state == fsw_st_status_write) & (cnt == 16'h0001);
  assign arr_done = (state == fsw_st_array) & array_done_in;

  always_comb begin
    next_state = state;
    case (state)
      fsw_st_idle: begin
        if (go_write_status_cmd) begin
          next_state = fsw_st_status_write;
        end else if (go_array) begin
          next_state = fsw_st_array;
        end
      end
      fsw_st_status_write: begin
        if (sw_done) begin
          next_state = fsw_st_idle;
        end
      end
      fsw_st_array: begin
        if (arr_done) begin
          next_state = fsw_st_idle;
        end
      end
      default: begin
        next_state = fsw_st_idle;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state   <= fsw_st_idle;
      ack_tgl <= 1'b0;
      cnt     <= 16'h0000;
    end else begin
      state   <= next_state;
      ack_tgl <= req_s2;
      if (go_write_status_cmd) begin
        cnt <= 16'(STATUS_WRITE_CYCLES);
      end else if (cnt != 16'h0000) begin
        cnt <= cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      write_enable_latch <= 1'b0;
    end else if (go_set) begin
      write_enable_latch <= 1'b1;
    end else if (go_clr | sw_done | arr_done) begin
      write_enable_latch <= 1'b0;
    end
  end

  // stored bits change only by status write
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      staged <= `FSW_STATUS_RESET;
      bp     <= 4'h0;
      qe     <= 1'b0;
      reg_write_disable   <= 1'b0;
    end else if (go_write_status_cmd) begin
      staged <= cmd_hold.data;
    end else if (sw_done) begin
      bp   <= staged[`FSW_BP_MSB:`FSW_BP_LSB];
      qe   <= staged[`FSW_QE_BIT];
      reg_write_disable <= staged[`FSW_REG_WRITE_DISABLE_BIT];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      array_op_out <= '0;
    end else begin
      array_op_out.start <= go_array;
      if (go_array) begin
        array_op_out.op    <= cmd_hold.op;
        array_op_out.block <= cmd_hold.block;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // core domain: outputs and status publication
  ////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_out      <= `FSW_STATUS_RESET;
      hold_active_out <= 1'b0;
    end else begin
      status_out      <= status_now;
      // hold input only while quad lines are off
      hold_active_out <= ~qe & ~hold_s2;
    end
  end

  // word stays put until the link side has taken it
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pub_tgl    <= 1'b0;
      pub_status <= `FSW_STATUS_RESET;
    end else if ((pub_tgl == pack_s2) && (pub_status != status_now)) begin
      pub_tgl    <= ~pub_tgl;
      pub_status <= status_now;
    end
  end

endmodule

`default_nettype wire

/* File: fsw_status_protect_assertions.sv */
// Purpose: port checks of the status and protect block
// Assumes: bound into fsw_status_protect
// Notes:   core and link domains, each with its own clock
`timescale 1ns/10ps
`default_nettype none
module fsw_status_protect_checker #(
  parameter int BLOCKS              = 256,
  parameter int STATUS_WRITE_CYCLES = 4
) (
  input wire logic                      mclk_in,
  input wire logic                      rst_n_in,
  input wire logic                      link_clk_in,
  input wire logic                      link_cmd_valid_in,
  input wire logic                      link_cmd_ready_out,
  input wire logic [7:0]                link_status_out,
  input wire logic [1:0]                link_quad_rx_out,
  input wire logic                      quad_data_line_two_oe_out,
  input wire logic [7:0]                function_reg_in,
  input wire logic                      array_done_in,
  input wire fsw_pkg::fsw_array_op_type array_op_out,
  input wire logic [7:0]                status_out,
  input wire logic                      hold_active_out
);
  import fsw_pkg::*;
  function automatic logic prot(input logic [3:0] bp, input logic tb, input logic [7:0] b);
    int c;
    int i;
    c = (bp == 4'h0) ? 0 : (1 << (bp - 4'h1));
    if (c > BLOCKS) c = BLOCKS;
    i = b % BLOCKS;
    return tb ? (i < c) : (i >= BLOCKS - c);
  endfunction
  ////////////////////////////////////////////////////////////////
  chk_start_busy: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    array_op_out.start |=> status_out[0]) else $error("busy not set by array op");
  chk_start_latch: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    array_op_out.start |-> status_out[1]) else $error("array op without latch");
  chk_write_latch: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $rose(status_out[0]) |-> status_out[1]) else $error("busy without latch");
  chk_latch_autoclear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $fell(status_out[0]) |-> !status_out[1]) else $error("latch kept after op");
  chk_done_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    array_done_in && status_out[0] |-> ##2 status_out[1:0] == 2'b00) else $error("done did not clear");
  chk_region_guard: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    array_op_out.start |-> !prot(status_out[5:2], function_reg_in[1], array_op_out.block))
    else $error("op started in protected block");
  chk_full_erase_bp: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    array_op_out.start && array_op_out.op == fsw_op_full_array_erase_cmd |-> status_out[5:2] == 4'h0)
    else $error("full erase with protect bits");
  chk_bits_via_write: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $changed(status_out[7:2]) |-> $past(status_out[0])) else $error("stored bits changed without write");
  chk_hold_quad: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    status_out[6] [*3] |-> !hold_active_out) else $error("hold active in quad mode");
  chk_rx_quiet: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    (!link_status_out[6]) [*3] |-> link_quad_rx_out == 2'b00) else $error("quad rx outside quad mode");
  chk_oe_quiet: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    (!link_status_out[6]) [*3] |-> !quad_data_line_two_oe_out) else $error("line two driven outside quad mode");
  chk_ready_return: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    link_cmd_valid_in && link_cmd_ready_out |=> (!link_cmd_ready_out) [*2] ##[1:2] link_cmd_ready_out)
    else $error("ready timing wrong");
endmodule
bind fsw_status_protect fsw_status_protect_checker #(.BLOCKS(BLOCKS), .STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) chk (
  .mclk_in, .rst_n_in, .link_clk_in, .link_cmd_valid_in, .link_cmd_ready_out, .link_status_out,
  .link_quad_rx_out, .quad_data_line_two_oe_out, .function_reg_in, .array_done_in, .array_op_out,
  .status_out, .hold_active_out);
`default_nettype wire

/* File: fsw_host_model.sv */
// Purpose: serial host issuing decoded commands on the link
// Assumes: link clock runs free
// Notes:   each put waits for the command to be acknowledged, then six link clocks
`timescale 1ns/10ps
`default_nettype none
module fsw_host_model (
  input  wire logic                 link_clk_in,
  input  wire logic                 ready_in,
  output var  logic                 valid_out,
  output var  fsw_pkg::fsw_cmd_type cmd_out
);
  import fsw_pkg::*;
  initial begin
    valid_out = 1'b0;
    cmd_out = '0;
  end
  task automatic put(input fsw_op_type o, input logic [7:0] d, input logic [7:0] b);
    int n;
    n = 0;
    @(posedge link_clk_in);
    #1;
    valid_out = 1'b1;
    cmd_out = {o, d, b};
    do @(posedge link_clk_in); while (ready_in !== 1'b1 && ++n < 12);
    #1;
    valid_out = 1'b0;
    cmd_out = ~cmd_out;
    n = 0;
    do @(posedge link_clk_in); while (ready_in !== 1'b1 && ++n < 12);
    repeat (6) @(posedge link_clk_in);
  endtask
  task automatic send(input fsw_op_type o, input logic [7:0] d, input logic [7:0] b);
    if (o > fsw_op_clear_write_latch_cmd) put(fsw_op_set_write_latch_cmd, 8'h00, 8'h00);
    put(o, d, b);
  endtask
endmodule
`default_nettype wire

/* File: flash_status_write_protect_bench.sv */
// Purpose: self-checking bench of the status and protect block
// Assumes: host model drives the link, bench drives the core side
// Notes:   short status write count
`timescale 1ns/10ps
`default_nettype none
module flash_status_write_protect_bench;
  import fsw_pkg::*;
  localparam int SWC = 4;
  logic             mclk_in = 1'b0;
  logic             lclk = 1'b0;
  logic             rst_n = 1'b0;
  logic             wp = 1'b1;
  logic             hold = 1'b1;
  logic             done = 1'b0;
  logic [1:0]       qtx = 2'h0;
  logic [1:0]       qoe = 2'h0;
  logic [7:0]       freg = 8'h00;
  logic             valid, ready, q2o, q2e, q3o, q3e, hact;
  logic [1:0]       qrx;
  logic [7:0]       lst, st;
  fsw_cmd_type      cmd;
  fsw_array_op_type aop;
  wire              q2i;
  wire              q3i;
  int               errors, check_count, starts, busy_n, cyc, seed;
  assign q2i = q2e ? q2o : wp;
  assign q3i = q3e ? q3o : hold;
  always #2 mclk_in = ~mclk_in;
  always #40 lclk = ~lclk;
  fsw_status_protect #(.BLOCKS(256), .STATUS_WRITE_CYCLES(SWC)) dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n), .link_clk_in(lclk), .link_cmd_valid_in(valid),
    .link_cmd_in(cmd), .link_cmd_ready_out(ready), .link_status_out(lst), .link_quad_tx_in(qtx),
    .link_quad_oe_in(qoe), .link_quad_rx_out(qrx), .quad_data_line_two_in(q2i),
    .quad_data_line_two_out(q2o), .quad_data_line_two_oe_out(q2e), .quad_data_line_three_in(q3i),
    .quad_data_line_three_out(q3o), .quad_data_line_three_oe_out(q3e), .function_reg_in(freg),
    .array_done_in(done), .array_op_out(aop), .status_out(st), .hold_active_out(hact));
  fsw_host_model host (.link_clk_in(lclk), .ready_in(ready), .valid_out(valid), .cmd_out(cmd));
  ////////////////////////////////////////////////////////////////
  function automatic int cnt(input logic [3:0] bp);
    return (bp == 4'h0) ? 0 : (bp > 4'h8) ? 256 : (1 << (bp - 4'h1));
  endfunction
  function automatic logic prot(input logic [3:0] bp, input logic tb, input logic [7:0] b);
    return tb ? (b < cnt(bp)) : (b >= 256 - cnt(bp));
  endfunction
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_st(input string nm, input logic [7:0] e);
    @(negedge lclk);
    check(nm, e, st);
    check(nm, e, lst);
  endtask
  task automatic fin;
    @(negedge mclk_in);
    done = 1'b1;
    @(negedge mclk_in);
    done = 1'b0;
    repeat (6) @(posedge lclk);
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (aop.start === 1'b1) starts++;
    if (st[0] === 1'b1) busy_n++;
    if (cyc == 80000) begin
      errors++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    int b0, s0;
    logic [3:0] bp;
    logic [7:0] blk;
    logic p;
    seed = 11;
    repeat (8) @(posedge lclk);
    @(negedge lclk);
    rst_n = 1'b1;
    chk_st("reset", 8'h00);
    host.put(fsw_op_set_write_latch_cmd, 8'h00, 8'h00);
    chk_st("set latch", 8'h02);
    host.put(fsw_op_clear_write_latch_cmd, 8'h00, 8'h00);
    chk_st("clear latch", 8'h00);
    s0 = starts;
    host.put(fsw_op_write_status_cmd, 8'h3C, 8'h00);
    host.put(fsw_op_page_program, 8'h00, 8'h00);
    chk_st("no latch", 8'h00);
    check("no latch start", 8'h00, 8'(starts - s0));
    b0 = busy_n;
    host.send(fsw_op_write_status_cmd, 8'h94, 8'h00);
    check("busy length", 8'(SWC), 8'(busy_n - b0));
    chk_st("lock set", 8'h94);
    @(negedge lclk);
    wp = 1'b0;
    host.send(fsw_op_write_status_cmd, 8'h00, 8'h00);
    chk_st("locked", 8'h96);
    @(negedge lclk);
    wp = 1'b1;
    host.send(fsw_op_write_status_cmd, 8'h04, 8'h00);
    chk_st("unlocked", 8'h04);
    s0 = starts;
    host.send(fsw_op_full_array_erase_cmd, 8'h00, 8'h00);
    check("erase guarded", 8'h00, 8'(starts - s0));
    host.send(fsw_op_write_status_cmd, 8'h00, 8'h00);
    host.send(fsw_op_full_array_erase_cmd, 8'h00, 8'h00);
    check("erase open", 8'h01, 8'(starts - s0));
    check("erase busy", 8'h01, {7'h00, st[0]});
    fin();
    chk_st("erase done", 8'h00);
    for (int i = 0; i < 24; i++) begin
      bp = 4'($random(seed));
      @(negedge lclk);
      freg = 8'($random(seed));
      case (i % 3)
        0: blk = 8'($random(seed));
        1: blk = 8'(freg[1] ? cnt(bp) - 1 : 256 - cnt(bp));
        default: blk = 8'(freg[1] ? cnt(bp) : 255 - cnt(bp));
      endcase
      host.send(fsw_op_write_status_cmd, {2'b00, bp, 2'b00}, 8'h00);
      s0 = starts;
      host.send(fsw_op_type'(3'(4 + i % 3)), 8'($random(seed)), blk);
      p = prot(bp, freg[1], blk);
      check("start", {7'h00, !p}, 8'(starts - s0));
      if (!p) begin
        check("op busy", 8'h01, {7'h00, st[0]});
        check("op code", {5'h00, 3'(4 + i % 3)}, {5'h00, aop.op});
        check("op block", blk, aop.block);
        fin();
      end
      chk_st("after op", {2'b00, bp, p, 1'b0});
    end
    @(negedge lclk);
    wp = 1'b0;
    hold = 1'b0;
    host.send(fsw_op_write_status_cmd, 8'h40, 8'h00);
    chk_st("quad on", 8'h40);
    check("hold off", 8'h00, {7'h00, hact});
    @(negedge lclk);
    qtx = 2'($random(seed));
    qoe = 2'h3;
    repeat (4) @(posedge lclk);
    check("quad oe", 8'h03, {6'h00, q3e, q2e});
    check("quad rx", {6'h00, qtx}, {6'h00, qrx});
    @(negedge lclk);
    qoe = 2'h0;
    {hold, wp} = 2'($random(seed));
    repeat (4) @(posedge lclk);
    check("quad in", {6'h00, hold, wp}, {6'h00, qrx});
    // quad off before pins act as controls
    @(negedge lclk);
    hold = 1'b0;
    host.send(fsw_op_write_status_cmd, 8'h00, 8'h00);
    check("hold on", 8'h01, {7'h00, hact});
    check("quad idle", 8'h00, {6'h00, qrx});
    conclude();
  end
endmodule
`default_nettype wire
